// ===== hw/jtag_membist_test_port.sv
// Scan port instruction decode, data registers and memory self-test engine
`timescale 1ns/100ps
`default_nettype none
module jtag_membist_test_port #(
	parameter int ADDR_W = 16,
	parameter logic [jtag_membist_pkg::PIN_CHAIN_LEN/2-1:0] BIDIR_MASK = '1,
	parameter logic [3:0] REV_CODE = 4'h0, // Arbitrary value
	parameter logic [15:0] PART_CODE = 16'h0abc, // Arbitrary value
	parameter logic [10:0] MAKER_CODE = 11'h05a // Arbitrary value
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic tck,
	input wire logic tdi,
	input wire logic tapReset,
	input wire logic tapRunIdle,
	input wire logic tapCaptureIr,
	input wire logic tapShiftIr,
	input wire logic tapUpdateIr,
	input wire logic tapCaptureDr,
	input wire logic tapShiftDr,
	input wire logic tapUpdateDr,
	input wire logic [jtag_membist_pkg::PIN_CHAIN_LEN-1:0] ringIn,
	input wire logic [71:0] memRdData,
	output logic tdo,
	output logic tdoOe,
	output logic scanDrive,
	output logic forceHighZ,
	output logic [jtag_membist_pkg::PIN_CHAIN_LEN/2-1:0] scanPinData,
	output logic [jtag_membist_pkg::PIN_CHAIN_LEN/2-1:0] scanPinOe,
	output logic [ADDR_W-1:0] memAddr,
	output logic [3:0] memWrEn,
	output logic [17:0] memWrData
);
	localparam int PINS = jtag_membist_pkg::PIN_CHAIN_LEN / 2;
	localparam int CL = jtag_membist_pkg::PIN_CHAIN_LEN;
	if (ADDR_W < 2 || ADDR_W > jtag_membist_pkg::PKT_ADDR_W) begin : g_chk
		$error("ADDR_W must lie in 2..16");
	end

	typedef struct packed {
		logic [2:0] startS;
		logic [1:0] modeS1;
		logic [1:0] modeS2;
		logic run;
		logic drain;
		logic debug;
		logic [3:0] phase;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] memAddr;
		logic [3:0] memWrEn;
		logic [17:0] memWrData;
		logic p1v;
		logic p2v;
		logic [17:0] p1exp;
		logic [17:0] p2exp;
		logic [ADDR_W-1:0] p1addr;
		logic [ADDR_W-1:0] p2addr;
		logic [5:0] p1code;
		logic [5:0] p2code;
		logic [23:0] cnt;
		logic [23:0] seen;
		logic [23:0] target;
		logic captured;
		logic more;
		logic [71:0] failBits;
		logic [ADDR_W-1:0] failAddr;
		logic [5:0] failCode;
		logic lastPkt;
		logic [24:0] result;
		logic doneTgl;
		logic pktTgl;
	} core_t;

	typedef struct packed {
		logic [CL-1:0] ringS1;
		logic [CL-1:0] ringS2;
		logic srstS1;
		logic srstS2;
		logic [2:0] doneS;
		logic [2:0] pktS;
		logic [3:0] ir;
		logic [3:0] irSr;
		logic [CL-1:0] dr;
		logic [CL-1:0] bsUpd;
		logic [1:0] ctrl;
		logic [1:0] modeHeld;
		logic startTgl;
		logic runIdleQ;
		logic [24:0] resSnap;
		logic [99:0] pktSr;
		logic [99:0] pktSnap;
		logic [6:0] pktCnt;
		logic drive;
		logic highZ;
		logic [PINS-1:0] pinData;
		logic [PINS-1:0] pinOe;
		logic inReset;
	} tck_t;

	core_t c_q, c_d;
	tck_t t_q, t_d;
	logic tdoQ;
	logic tdoOeQ;

	function automatic logic [17:0] pattern(input jtag_membist_pkg::pat_t p,
		input logic [ADDR_W-1:0] a);
		logic [17:0] chk;
		chk = {9{2'b01}} ^ {18{a[0] ^ a[ADDR_W-1]}};
		case (p)
			jtag_membist_pkg::PAT_ZERO: pattern = '0;
			jtag_membist_pkg::PAT_CHK: pattern = chk;
			jtag_membist_pkg::PAT_NCHK: pattern = ~chk;
			default: pattern = 18'(a);
		endcase
	endfunction : pattern

	function automatic int dr_len(input logic [3:0] ir);
		case (ir)
			jtag_membist_pkg::INSTR_EXTEST,
			jtag_membist_pkg::INSTR_SAMPLE: dr_len = CL;
			jtag_membist_pkg::INSTR_IDCODE: dr_len = jtag_membist_pkg::ID_LEN;
			jtag_membist_pkg::INSTR_RESULT_SCAN: dr_len = jtag_membist_pkg::RESULT_LEN;
			jtag_membist_pkg::INSTR_CONTROL_SCAN: dr_len = jtag_membist_pkg::CTRL_LEN;
			jtag_membist_pkg::INSTR_SELFTEST: dr_len = jtag_membist_pkg::PACKET_LEN;
			default: dr_len = jtag_membist_pkg::BYPASS_LEN;
		endcase
	endfunction : dr_len

	// Self-test engine, self-test clock domain
	logic [71:0] cmp;
	logic startEv;
	jtag_membist_pkg::phase_t ph;
	always_comb begin
		c_d = c_q;
		c_d.startS = {c_q.startS[1:0], t_q.startTgl};
		c_d.modeS1 = t_q.modeHeld;
		c_d.modeS2 = c_q.modeS1;
		startEv = c_q.startS[2] ^ c_q.startS[1];
		ph = jtag_membist_pkg::phase_info(c_q.phase);
		cmp = memRdData ^ {4{c_q.p2exp}};
		c_d.memWrEn = '0;
		c_d.p1v = 1'b0;
		c_d.p2v = c_q.p1v;
		c_d.p2exp = c_q.p1exp;
		c_d.p2addr = c_q.p1addr;
		c_d.p2code = c_q.p1code;
		if (c_q.p2v && (|cmp)) begin
			if (c_q.cnt != '1) begin
				c_d.cnt = c_q.cnt + 24'h00_0001;
			end
			if (c_q.seen != '1) begin
				c_d.seen = c_q.seen + 24'h00_0001;
			end
			if (c_q.debug && !c_q.captured && c_q.seen == c_q.target) begin
				c_d.captured = 1'b1;
				c_d.failBits = cmp;
				c_d.failAddr = c_q.p2addr;
				c_d.failCode = c_q.p2code;
			end else if (c_q.captured) begin
				c_d.more = 1'b1;
			end
		end
		if (startEv && !c_q.run) begin
			c_d.run = 1'b1;
			c_d.drain = 1'b0;
			c_d.phase = '0;
			c_d.addr = '0;
			c_d.cnt = '0;
			c_d.seen = '0;
			c_d.captured = 1'b0;
			c_d.more = 1'b0;
			c_d.debug = (c_q.modeS2 == jtag_membist_pkg::MODE_DEBUG);
			if (c_q.modeS2 == jtag_membist_pkg::MODE_GONOGO) begin
				c_d.target = '0;
			end
		end else if (c_q.run && !c_q.drain) begin
			c_d.memAddr = c_q.addr;
			if (ph.wr) begin
				c_d.memWrEn[ph.writer] = 1'b1;
				c_d.memWrData = pattern(ph.pat, c_q.addr);
			end else begin
				c_d.p1v = 1'b1;
				c_d.p1exp = pattern(ph.pat, c_q.addr);
				c_d.p1addr = c_q.addr;
				c_d.p1code = ph.code;
			end
			c_d.addr = c_q.addr + 1'b1;
			if (c_q.addr == '1) begin
				if (c_q.phase == jtag_membist_pkg::LAST_PHASE) begin
					c_d.drain = 1'b1;
				end else begin
					c_d.phase = c_q.phase + 4'h1;
				end
			end
		end else if (c_q.run && !c_q.p1v && !c_q.p2v) begin
			// Result frozen until the next start, extra clocks do nothing
			c_d.run = 1'b0;
			c_d.result = {c_q.cnt, c_q.cnt != '0};
			c_d.doneTgl = ~c_q.doneTgl;
			if (c_q.debug && c_q.captured) begin
				c_d.lastPkt = ~c_q.more;
				c_d.pktTgl = ~c_q.pktTgl;
				c_d.target = c_q.target + 24'h00_0001;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	// Scan logic, TCK domain
	logic rst;
	int len;
	logic [99:0] pkt;
	always_comb begin
		t_d = t_q;
		t_d.ringS1 = ringIn;
		t_d.ringS2 = t_q.ringS1;
		t_d.srstS1 = srst;
		t_d.srstS2 = t_q.srstS1;
		t_d.doneS = {t_q.doneS[1:0], c_q.doneTgl};
		t_d.pktS = {t_q.pktS[1:0], c_q.pktTgl};
		t_d.runIdleQ = tapRunIdle;
		rst = tapReset | t_q.srstS2;
		t_d.inReset = rst;
		len = dr_len(t_q.ir);
		pkt = '0;
		pkt[99:98] = jtag_membist_pkg::PKT_MARK;
		for (int i = 0; i < 72; i++) begin
			pkt[jtag_membist_pkg::PKT_FAIL_MSB - i] = c_q.failBits[i];
		end
		pkt[jtag_membist_pkg::PKT_ADDR_LSB +: jtag_membist_pkg::PKT_ADDR_W] =
			16'(c_q.failAddr);
		pkt[jtag_membist_pkg::PKT_STATE_LSB +: 6] = c_q.failCode;
		pkt[jtag_membist_pkg::PKT_DONE_BIT] = c_q.lastPkt;
		pkt[1:0] = jtag_membist_pkg::PKT_MARK;
		if (tapCaptureIr) begin
			t_d.irSr = jtag_membist_pkg::IR_CAPTURE_VAL;
		end else if (tapShiftIr) begin
			t_d.irSr = {tdi, t_q.irSr[3:1]};
		end else if (tapUpdateIr) begin
			t_d.ir = t_q.irSr;
		end
		if (tapCaptureDr) begin
			case (t_q.ir)
				jtag_membist_pkg::INSTR_EXTEST,
				jtag_membist_pkg::INSTR_SAMPLE: t_d.dr = t_q.ringS2;
				jtag_membist_pkg::INSTR_IDCODE: t_d.dr[31:0] = {REV_CODE, PART_CODE,
					MAKER_CODE, jtag_membist_pkg::ID_PRESENT};
				jtag_membist_pkg::INSTR_RESULT_SCAN: t_d.dr[24:0] = t_q.resSnap;
				jtag_membist_pkg::INSTR_CONTROL_SCAN: t_d.dr[1:0] = t_q.ctrl;
				jtag_membist_pkg::INSTR_SELFTEST: t_d.dr[99:0] = t_q.pktSnap;
				default: t_d.dr[0] = 1'b0;
			endcase
		end else if (tapShiftDr) begin
			t_d.dr = t_q.dr >> 1;
			t_d.dr[len - 1] = tdi;
		end else if (tapUpdateDr) begin
			if (t_q.ir == jtag_membist_pkg::INSTR_EXTEST || t_q.ir == jtag_membist_pkg::INSTR_SAMPLE) begin
				t_d.bsUpd = t_q.dr;
			end
			if (t_q.ir == jtag_membist_pkg::INSTR_CONTROL_SCAN) begin
				t_d.ctrl = t_q.dr[1:0];
			end
		end
		// Mode latched with the start so the crossing sees a stable value
		if (tapRunIdle && !t_q.runIdleQ && t_q.ir == jtag_membist_pkg::INSTR_SELFTEST
			&& (t_q.ctrl == jtag_membist_pkg::MODE_GONOGO
			|| t_q.ctrl == jtag_membist_pkg::MODE_DEBUG)) begin
			t_d.startTgl = ~t_q.startTgl;
			t_d.modeHeld = t_q.ctrl;
		end
		if (t_q.doneS[2] ^ t_q.doneS[1]) begin
			t_d.resSnap = c_q.result;
		end
		if (t_q.pktCnt != '0) begin
			t_d.pktSr = t_q.pktSr << 1;
			t_d.pktCnt = t_q.pktCnt - 7'h01;
		end
		if ((t_q.pktS[2] ^ t_q.pktS[1]) && t_q.ir == jtag_membist_pkg::INSTR_SELFTEST) begin
			t_d.pktSr = pkt;
			t_d.pktSnap = pkt;
			t_d.pktCnt = jtag_membist_pkg::PKT_SHIFT_LEN;
		end
		t_d.drive = (t_q.ir == jtag_membist_pkg::INSTR_EXTEST)
			|| (t_q.ir == jtag_membist_pkg::INSTR_CLAMP);
		t_d.highZ = (t_q.ir == jtag_membist_pkg::INSTR_HIGHZ);
		for (int p = 0; p < PINS; p++) begin
			t_d.pinData[p] = t_q.bsUpd[2 * p];
			t_d.pinOe[p] = BIDIR_MASK[p] ? t_q.bsUpd[2 * p + 1] : 1'b1;
		end
		if (rst) begin
			t_d.ir = jtag_membist_pkg::INSTR_IDCODE;
			t_d.irSr = jtag_membist_pkg::INSTR_IDCODE;
			t_d.pktCnt = '0;
		end
		if (t_q.srstS2) begin
			t_d.ctrl = jtag_membist_pkg::CTRL_RESET_VAL;
			// Start toggle cleared with the engine, else it never leaves unknown
			t_d.startTgl = 1'b0;
			t_d.modeHeld = jtag_membist_pkg::MODE_GONOGO;
		end
	end
	always_ff @(posedge tck) begin
		t_q <= t_d;
	end

	// Falling-edge output stage gives the far end half a period of hold
	always_ff @(negedge tck) begin
		if (t_q.inReset) begin
			tdoQ <= 1'b0;
			tdoOeQ <= 1'b0;
		end else begin
			tdoQ <= (t_q.pktCnt != '0) ? t_q.pktSr[99] :
				tapShiftIr ? t_q.irSr[0] : t_q.dr[0];
			tdoOeQ <= tapShiftIr || tapShiftDr || (t_q.pktCnt != '0);
		end
	end

	assign tdo = tdoQ;
	assign tdoOe = tdoOeQ;
	assign scanDrive = t_q.drive;
	assign forceHighZ = t_q.highZ;
	assign scanPinData = t_q.pinData;
	assign scanPinOe = t_q.pinOe;
	assign memAddr = c_q.memAddr;
	assign memWrEn = c_q.memWrEn;
	assign memWrData = c_q.memWrData;

	chk_ir_reset_load: assert property (@(posedge tck)
		tapReset |=> t_q.ir == jtag_membist_pkg::INSTR_IDCODE)
		else $error("instruction not identification after reset");
	chk_capture_ir_pattern: assert property (@(posedge tck) disable iff (tapReset)
		tapCaptureIr |=> t_q.irSr[1:0] == 2'b01)
		else $error("capture-ir pattern wrong");
	chk_bypass_path: assert property (@(posedge tck) disable iff (rst)
		tapShiftDr && !tapCaptureDr && t_q.ir == jtag_membist_pkg::INSTR_BYPASS
		|=> t_q.dr[0] == $past(tdi))
		else $error("bypass bit did not take tdi");
	chk_id_capture: assert property (@(posedge tck) disable iff (rst)
		tapCaptureDr && t_q.ir == jtag_membist_pkg::INSTR_IDCODE |=> t_q.dr[0] == 1'b1
		&& t_q.dr[31:28] == REV_CODE && t_q.dr[11:1] == MAKER_CODE)
		else $error("identification capture wrong");
	chk_highz_force: assert property (@(posedge tck) disable iff (rst)
		t_q.ir == jtag_membist_pkg::INSTR_HIGHZ |=> forceHighZ && !scanDrive)
		else $error("high-z not forced");
	chk_ctrl_reset: assert property (@(posedge tck)
		t_q.srstS2 |=> t_q.ctrl == jtag_membist_pkg::CTRL_RESET_VAL)
		else $error("control register not cleared");
	chk_packet_frame: assert property (@(posedge tck) disable iff (rst)
		t_q.pktCnt == jtag_membist_pkg::PKT_SHIFT_LEN |-> t_q.pktSr[99:98] == 2'b11
		&& t_q.pktSr[1:0] == 2'b11 ##1 t_q.pktSr[99] == 1'b1)
		else $error("packet header or trailer missing");
	chk_count_saturate: assert property (@(posedge core_clk) disable iff (srst)
		c_q.cnt != '0 && !startEv |=> c_q.cnt != '0)
		else $error("failure count wrapped to zero");
	chk_pass_bit: assert property (@(posedge core_clk) disable iff (srst)
		c_q.run && !c_d.run |=> c_q.result[0] == (c_q.result[24:1] != '0))
		else $error("pass-fail bit disagrees with count");
	chk_done_hold: assert property (@(posedge core_clk) disable iff (srst)
		!c_q.run && !startEv |=> $stable(c_q.result) && !c_q.run && c_q.memWrEn == '0)
		else $error("engine changed after completion");
endmodule : jtag_membist_test_port
`default_nettype wire

// ===== hw/jtag_membist_pkg.sv
// Constants and types shared by the scan port and its memory self-test engine
package jtag_membist_pkg;
	// Instruction codes
	localparam logic [3:0] INSTR_EXTEST = 4'h0;
	localparam logic [3:0] INSTR_SAMPLE = 4'h1;
	localparam logic [3:0] INSTR_RESULT_SCAN = 4'h2;
	localparam logic [3:0] INSTR_CONTROL_SCAN = 4'h3;
	localparam logic [3:0] INSTR_CLAMP = 4'h5;
	localparam logic [3:0] INSTR_HIGHZ = 4'h6;
	localparam logic [3:0] INSTR_IDCODE = 4'h7;
	localparam logic [3:0] INSTR_SELFTEST = 4'h8;
	localparam logic [3:0] INSTR_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
	// Scan register lengths
	localparam int IR_LEN = 4;
	localparam int BYPASS_LEN = 1;
	localparam int ID_LEN = 32;
	localparam int CTRL_LEN = 2;
	localparam int RESULT_LEN = 25;
	localparam int PACKET_LEN = 100;
	localparam int PIN_CHAIN_LEN = 392;
	// Identification layout
	localparam int ID_REV_LSB = 28;
	localparam int ID_PART_LSB = 12;
	localparam int ID_MFR_LSB = 1;
	localparam logic ID_PRESENT = 1'h1;
	// Self-test control values
	localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
	localparam logic [1:0] MODE_GONOGO = 2'h0;
	localparam logic [1:0] MODE_DEBUG = 2'h1;
	// Failure packet layout
	localparam int PKT_FAIL_MSB = 97;
	localparam int PKT_ADDR_LSB = 10;
	localparam int PKT_ADDR_W = 16;
	localparam int PKT_STATE_LSB = 4;
	localparam int PKT_DONE_BIT = 2;
	localparam logic [1:0] PKT_MARK = 2'h3;
	localparam logic [6:0] PKT_SHIFT_LEN = 7'h64;
	// Memory geometry and timing
	localparam int PORT_W = 18;
	localparam int NUM_PORTS = 4;
	localparam int CNT_W = 24;
	localparam int SELFTEST_OPS = 31195136;
	localparam int SYNC_PAD_MIN = 4;
	localparam int SYNC_PAD_MAX = 6;
	localparam logic [3:0] LAST_PHASE = 4'hb;
	typedef enum logic [1:0] {PAT_ZERO, PAT_CHK, PAT_NCHK, PAT_UADDR} pat_t;
	typedef struct packed {
		logic [5:0] code;
		logic [1:0] writer;
		logic wr;
		pat_t pat;
	} phase_t;
	function automatic phase_t phase_info(input logic [3:0] ph);
		case (ph)
			4'h0: phase_info = '{6'h01, 2'h0, 1'b1, PAT_ZERO};
			4'h1: phase_info = '{6'h05, 2'h0, 1'b0, PAT_ZERO};
			4'h2: phase_info = '{6'h0b, 2'h0, 1'b1, PAT_CHK};
			4'h3: phase_info = '{6'h09, 2'h0, 1'b0, PAT_CHK};
			4'h4: phase_info = '{6'h08, 2'h0, 1'b1, PAT_NCHK};
			4'h5: phase_info = '{6'h18, 2'h0, 1'b0, PAT_NCHK};
			4'h6: phase_info = '{6'h1b, 2'h1, 1'b1, PAT_UADDR};
			4'h7: phase_info = '{6'h1a, 2'h1, 1'b0, PAT_UADDR};
			4'h8: phase_info = '{6'h1b, 2'h2, 1'b1, PAT_UADDR};
			4'h9: phase_info = '{6'h1a, 2'h2, 1'b0, PAT_UADDR};
			4'ha: phase_info = '{6'h1b, 2'h3, 1'b1, PAT_UADDR};
			default: phase_info = '{6'h1a, 2'h3, 1'b0, PAT_UADDR};
		endcase
	endfunction : phase_info
endpackage : jtag_membist_pkg

// ===== verif/scan_ctrl_model.sv
// Behavioural board scan controller driving the test port
`timescale 1ns/100ps
`default_nettype none
module scan_ctrl_model (
	output logic tck,
	output logic tdi,
	output logic [7:0] lvl,
	input wire logic tdo,
	input wire logic tdoOe
);
	// lvl bits: reset, run-idle, IR capture/shift/update, DR capture/shift/update
	initial begin
		tck = 1'b1;
		tdi = 1'b1;
		lvl = 8'h00;
	end
	// Clock stands high between frames; idle tdi sits at its pull-up level
	task automatic cyc(input logic [7:0] l, input logic d, output logic q, output logic oe);
		lvl = l;
		tdi = d;
		#61.5 tck = 1'b0;
		// No pull on tdo: a released pin reads inverted so a missing enable shows
		#62.5 q = (tdoOe === 1'b1) ? tdo : ~tdo; // Taken just before the rise
		oe = tdoOe;
		tck = 1'b1;
		#1;
	endtask : cyc
	task automatic scan(input logic ir, input int len, input logic [391:0] din,
		output logic [391:0] dout);
		logic q;
		logic oe;
		dout = '0;
		cyc(ir ? 8'h20 : 8'h04, 1'b1, q, oe);
		for (int i = 0; i < len; i++) begin
			cyc(ir ? 8'h10 : 8'h02, din[i], q, oe);
			dout[i] = q;
		end
		cyc(ir ? 8'h08 : 8'h01, 1'b1, q, oe);
	endtask : scan
	// Sit in Run-Test/Idle and collect whatever the port pushes out
	task automatic run(input int n, output logic [99:0] pk, output int nOe);
		logic q;
		logic oe;
		pk = '0;
		nOe = 0;
		for (int i = 0; i < n; i++) begin
			cyc(8'h40, 1'b1, q, oe);
			if (oe === 1'b1) begin
				pk = {pk[98:0], q};
				nOe++;
			end
		end
	endtask : run
endmodule : scan_ctrl_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the scan port and its memory self-test
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [31:0] ID_EXP = {4'h3, 16'h5a5a, 11'h02c1, 1'b1};
	localparam logic [5:0] TBL [4] = '{6'h20, 6'h25, 6'h16, 6'h0f};
	localparam logic [5:0] RD_CODE [6] = '{6'h05, 6'h09, 6'h18, 6'h1a, 6'h1a, 6'h1a};
	logic core_clk;
	logic srst;
	logic tck;
	logic tdi;
	logic tdo;
	logic tdoOe;
	logic scanDrive;
	logic forceHighZ;
	logic [7:0] lvl;
	logic [391:0] ringIn;
	logic [71:0] memRdData;
	logic [195:0] scanPinData;
	logic [195:0] scanPinOe;
	logic [3:0] memAddr;
	logic [3:0] memWrEn;
	logic [17:0] memWrData;
	logic [17:0] mem [16];
	logic [17:0] rdWord;
	logic faultOn;
	logic [3:0] faultAddr;
	int faultBit;
	int nFail = 0;
	int nCompared = 0;
	// Identity values are arbitrary
	jtag_membist_test_port #(.ADDR_W(4), .REV_CODE(4'h3), .PART_CODE(16'h5a5a),
		.MAKER_CODE(11'h02c1)) i_dut (
		.core_clk(core_clk), .srst(srst), .tck(tck), .tdi(tdi), .tapReset(lvl[7]),
		.tapRunIdle(lvl[6]), .tapCaptureIr(lvl[5]), .tapShiftIr(lvl[4]),
		.tapUpdateIr(lvl[3]), .tapCaptureDr(lvl[2]), .tapShiftDr(lvl[1]),
		.tapUpdateDr(lvl[0]), .ringIn(ringIn), .memRdData(memRdData), .tdo(tdo),
		.tdoOe(tdoOe), .scanDrive(scanDrive), .forceHighZ(forceHighZ),
		.scanPinData(scanPinData), .scanPinOe(scanPinOe), .memAddr(memAddr),
		.memWrEn(memWrEn), .memWrData(memWrData));
	scan_ctrl_model i_ctrl (.tck(tck), .tdi(tdi), .lvl(lvl), .tdo(tdo), .tdoOe(tdoOe));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [391:0] got, input logic [391:0] exp);
		nCompared++;
		if (got !== exp) begin
			nFail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	function automatic logic [391:0] rnd();
		for (int i = 0; i < 392; i++)
			rnd[i] = 1'($urandom);
	endfunction : rnd
	// Word the self-test expects back in each phase
	function automatic logic [17:0] expWord(input int ph, input logic [3:0] a);
		logic [17:0] chk;
		chk = 18'h1_5555 ^ {18{a[0] ^ a[3]}};
		if (ph < 2) return 18'h0_0000;
		if (ph < 4) return chk;
		if (ph < 6) return ~chk;
		return 18'(a);
	endfunction : expWord
	// Only documented codes are ever loaded
	task automatic loadIr(input logic [3:0] c, output logic [391:0] d);
		i_ctrl.scan(1'b1, 4, 392'(c), d);
	endtask : loadIr
	task automatic idCheck();
		logic [391:0] d;
		i_ctrl.scan(1'b0, 32, '1, d);
		check(392'(d[31:0]), 392'(ID_EXP));
	endtask : idCheck
	// Shared array; one cell bit stuck high while a fault is armed
	always @(posedge core_clk) begin
		rdWord = mem[memAddr];
		if (faultOn && memAddr == faultAddr) rdWord[faultBit] = 1'b1;
		memRdData <= #1 {4{rdWord}};
		if (memWrEn != 4'h0) mem[memAddr] <= #1 memWrData;
	end
	always @(negedge core_clk) begin
		if (memWrEn > 4'h1) check(392'(memWrData), 392'(memAddr));
		if ((memWrEn & (memWrEn - 4'h1)) != 4'h0) check(392'(memWrEn), 392'(0));
	end
	initial begin
		#1_000_000;
		nFail++;
		end_of_test();
	end
	initial begin
		logic [391:0] d;
		logic [391:0] v;
		logic [195:0] pd;
		logic [195:0] po;
		logic [99:0] pk;
		logic [71:0] fv;
		logic [17:0] w;
		logic [5:0] codes[$];
		logic q;
		logic oe;
		int nOe;
		void'($urandom(32'h01c1_931a));
		srst = 1'b1;
		faultOn = 1'b0;
		faultAddr = 4'h0;
		faultBit = 0;
		ringIn = rnd();
		repeat (2) @(posedge core_clk);
		repeat (3) i_ctrl.cyc(8'h80, 1'b1, q, oe);
		@(posedge core_clk);
		#1 srst = 1'b0;
		#8;
		repeat (4) i_ctrl.cyc(8'h00, 1'b1, q, oe);
		idCheck();
		foreach (TBL[i]) begin
			loadIr(TBL[i][3:0], d);
			check(392'(d[1:0]), 392'(2'b01));
			v = rnd();
			i_ctrl.scan(1'b0, 8, v, d);
			check(392'({scanDrive, forceHighZ}), 392'(TBL[i][5:4]));
			w = (TBL[i][3:0] == 4'h0) ? 18'(ringIn[7:0]) : 18'({v[6:0], 1'b0});
			check(392'(d[7:0]), 392'(w[7:0]));
		end
		loadIr(4'h1, d);
		v = rnd();
		i_ctrl.scan(1'b0, 392, v, d);
		check(d, ringIn);
		loadIr(4'h0, d);
		i_ctrl.cyc(8'h00, 1'b1, q, oe);
		for (int p = 0; p < 196; p++) begin
			pd[p] = v[2 * p];
			po[p] = v[2 * p + 1];
		end
		check(392'({scanPinData, scanPinOe}), 392'({pd, po}));
		i_ctrl.cyc(8'h80, 1'b1, q, oe);
		i_ctrl.cyc(8'h00, 1'b1, q, oe);
		idCheck();
		loadIr(4'h3, d);
		i_ctrl.scan(1'b0, 2, 392'(2'b00), d);
		check(392'(d[1:0]), 392'(2'b00));
		// Go/no-go ahead of debug bounds the packet count
		for (int f = 0; f < 2; f++) begin
			faultOn = (f == 1);
			faultAddr = 4'($urandom);
			faultBit = $urandom % 18;
			codes = {};
			for (int r = 0; r < 6; r++) begin
				w = expWord(2 * r + 1, faultAddr);
				if (faultOn && !w[faultBit]) codes.push_back(RD_CODE[r]);
			end
			loadIr(4'h8, d);
			i_ctrl.run(60, pk, nOe);
			check(392'(nOe), 392'(0));
			loadIr(4'h2, d);
			repeat (2) begin
				i_ctrl.scan(1'b0, 25, '1, d);
				check(392'(d[24:0]), 392'({24'(codes.size()), codes.size() != 0}));
				i_ctrl.run(20, pk, nOe);
			end
		end
		// Control 10 starts nothing, so the last result must stand
		loadIr(4'h3, d);
		i_ctrl.scan(1'b0, 2, 392'(2'b10), d);
		loadIr(4'h8, d);
		i_ctrl.run(60, pk, nOe);
		check(392'(nOe), 392'(0));
		loadIr(4'h2, d);
		i_ctrl.scan(1'b0, 25, '1, d);
		check(392'(d[24:0]), 392'({24'(codes.size()), codes.size() != 0}));
		loadIr(4'h3, d);
		i_ctrl.scan(1'b0, 2, 392'(2'b01), d);
		check(392'(d[1:0]), 392'(2'b10));
		fv = '0;
		for (int p = 0; p < 4; p++)
			fv[71 - (p * 18 + faultBit)] = 1'b1;
		foreach (codes[k]) begin
			loadIr(4'h8, d);
			i_ctrl.run(200, pk, nOe);
			check(392'(nOe), 392'(100));
			v = 392'({2'b11, fv, 12'h000, faultAddr, codes[k], 1'b0, k == codes.size() - 1, 2'b11});
			check(392'(pk), v);
		end
		end_of_test();
	end
endmodule : tb
`default_nettype wire
